// ### hdl/smbus_temp_pkg.sv
// constants and carrier types shared by the temperature readout block
// assumes a 200 MHz system clock
package smbus_temp_pkg;

  localparam int CLK_MHZ          = 200;
  localparam int TIMEOUT_MS       = 35;
  localparam int TIMEOUT_CYCLES   = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int ROUND_PERIOD_MS  = 1000;
  localparam int ROUND_GAP_CYCLES = ROUND_PERIOD_MS * CLK_MHZ * 1000;

  localparam logic [6:0] SLAVE_ADDR_LOW  = 7'h18;
  localparam logic [6:0] SLAVE_ADDR_MID  = 7'h2a;
  localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h2b;

  localparam logic [7:0] OFS_STATUS   = 8'h02;
  localparam logic [7:0] OFS_CHAN_EN  = 8'h08;
  localparam logic [7:0] OFS_FILTER   = 8'h0f;
  localparam logic [7:0] OFS_LIMIT1   = 8'h40;
  localparam logic [7:0] OFS_LIMIT2   = 8'h41;
  localparam logic [7:0] OFS_POINTER_RESET = 8'h00;

  // temperature pairs: local, r1 signed, r2 signed, r1 unsigned, r2 unsigned
  localparam int NPAIR = 5;
  localparam logic [7:0] OFS_MSB [NPAIR] = '{8'h00, 8'h10, 8'h11, 8'h18, 8'h19};
  localparam logic [7:0] OFS_LSB [NPAIR] = '{8'h30, 8'h20, 8'h21, 8'h28, 8'h29};

  localparam int BUSY_BIT = 7;
  localparam int FILT_R1_LSB = 0;
  localparam int FILT_R2_LSB = 2;

  localparam logic [2:0] CHAN_EN_RESET = 3'h7;
  localparam logic [3:0] FILTER_RESET  = 4'hf;
  localparam logic [7:0] LIMIT1_RESET  = 8'h6e;
  localparam logic [7:0] LIMIT2_RESET  = 8'h55;

  localparam logic [1:0] FILT_NONE  = 2'h0;
  localparam logic [1:0] FILT_BASIC = 2'h1;
  localparam logic [1:0] FILT_RSVD  = 2'h2;
  localparam logic [1:0] FILT_ENH   = 2'h3;

  localparam logic [1:0] CH_LOCAL   = 2'h0;
  localparam logic [1:0] CH_REMOTE1 = 2'h1;
  localparam logic [1:0] CH_REMOTE2 = 2'h2;

  // temperatures internally in 1/32 degree steps
  localparam logic signed [16:0] TEMP_S_MIN = -17'sh01000;
  localparam logic signed [16:0] TEMP_S_MAX = 17'sh00fff;
  localparam logic signed [16:0] TEMP_U_MAX = 17'sh01fff;
  localparam logic signed [16:0] CLIP_STEP  = 17'sh00020;
  localparam int FILT_SHIFT = 2;

  typedef struct packed {
    logic       start;
    logic [1:0] chan;
  } conv_req_t;

  typedef struct packed {
    logic        done;
    logic [1:0]  chan;
    logic [15:0] value;
  } conv_result_t;

endpackage

// ### hdl/smbus_temp_sensor_readout.sv
// readout, sequencing and bus slave of a three-channel temperature sensor
// assumes a converter on clk answering each start with one done strobe,
// and bus pins from outside the clock domain, resolved by the bench
`timescale 1ns/1ps
`default_nettype none

module smbus_temp_sensor_readout #(
  parameter int TIMEOUT_CYCLES_P = smbus_temp_pkg::TIMEOUT_CYCLES,
  parameter int GAP_CYCLES_P     = smbus_temp_pkg::ROUND_GAP_CYCLES
) (
  // clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         ce,
  // bus pins
  input  wire logic                         smb_clk_pin,
  input  wire logic                         smb_dat_in,
  output logic                              smb_dat_out,
  output logic                              smb_dat_oe,
  // three-level select: 00 low, 01 mid, 1x high
  input  wire logic [1:0]                   address_select_pin,
  // converter
  output smbus_temp_pkg::conv_req_t         conv_req,
  input  wire smbus_temp_pkg::conv_result_t conv_result,
  // critical alarms, open drain
  output logic                              critical_alarm_out_one,
  output logic                              critical_alarm_out_one_oe,
  output logic                              critical_alarm_out_two,
  output logic                              critical_alarm_out_two_oe,
  output logic                              critical_alarm_out_three,
  output logic                              critical_alarm_out_three_oe
);

  localparam int NP = smbus_temp_pkg::NPAIR;
  localparam int TW = $clog2(TIMEOUT_CYCLES_P + 1);
  localparam int GW = $clog2(GAP_CYCLES_P + 1);

  if (TIMEOUT_CYCLES_P < 2 || GAP_CYCLES_P < 1) begin : bad_param
    $error("timeout must be at least 2 cycles and gap at least 1");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WDATA, S_WDATA_ACK, S_READ, S_READ_ACK
  } bus_state_t;
  typedef enum logic [1:0] {SQ_GAP, SQ_START, SQ_WAIT} seq_state_t;

  function automatic logic [6:0] decode_addr(input logic [1:0] lvl);
    if (lvl[1]) return smbus_temp_pkg::SLAVE_ADDR_HIGH;
    else if (lvl[0]) return smbus_temp_pkg::SLAVE_ADDR_MID;
    else return smbus_temp_pkg::SLAVE_ADDR_LOW;
  endfunction

  // lowest enabled channel at or above from, msb flags found
  function automatic logic [2:0] first_from(input logic [2:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) r = {1'b1, 2'(i)};
    end
    return r;
  endfunction

  // clamp and left-justify a 1/32 degree value
  function automatic logic [15:0] fmt(input logic signed [15:0] v, input logic uns,
                                      input logic fine);
    logic signed [16:0] c;
    c = 17'(v);
    if (uns) begin
      if (c < 0) c = 17'sh0;
      else if (c > smbus_temp_pkg::TEMP_U_MAX) c = smbus_temp_pkg::TEMP_U_MAX;
    end else begin
      if (c < smbus_temp_pkg::TEMP_S_MIN) c = smbus_temp_pkg::TEMP_S_MIN;
      else if (c > smbus_temp_pkg::TEMP_S_MAX) c = smbus_temp_pkg::TEMP_S_MAX;
    end
    if (!fine) c[1:0] = 2'h0;
    return {c[12:0], 3'h0};
  endfunction

  // pin synchronisers, third stage for edges
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_q, sda_q;
  logic [1:0] asel_s1_q, asel_s2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      asel_s1_q  <= 2'h0;
      asel_s2_q  <= 2'h0;
    end else if (ce) begin
      scl_sync_q <= {scl_sync_q[0], smb_clk_pin};
      sda_sync_q <= {sda_sync_q[0], smb_dat_in};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
      asel_s1_q  <= address_select_pin;
      asel_s2_q  <= asel_s1_q;
    end
  end

  wire scl      = scl_sync_q[1];
  wire sda      = sda_sync_q[1];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_ev = scl & scl_q & sda_q & ~sda;
  wire stop_ev  = scl & scl_q & ~sda_q & sda;

  // slave address, caught once after reset
  logic [1:0] addr_wait_q;
  logic       addr_done_q;
  logic [6:0] slave_addr_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_wait_q  <= 2'h0;
      addr_done_q  <= 1'b0;
      slave_addr_q <= smbus_temp_pkg::SLAVE_ADDR_LOW;
    end else if (ce && !addr_done_q) begin
      addr_wait_q <= addr_wait_q + 2'h1;
      if (addr_wait_q == 2'h3) begin
        addr_done_q  <= 1'b1;
        slave_addr_q <= decode_addr(asel_s2_q);
      end
    end
  end

  // bus timeout
  logic [TW-1:0] to_cnt_q;
  wire lines_low = ~scl | ~sda;
  wire to_hit    = lines_low && (to_cnt_q == TW'(TIMEOUT_CYCLES_P - 1));
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) to_cnt_q <= '0;
    else if (ce) begin
      if (!lines_low) to_cnt_q <= '0;
      else if (to_cnt_q != TW'(TIMEOUT_CYCLES_P)) to_cnt_q <= to_cnt_q + TW'(1);
    end
  end

  // configuration and results
  logic [2:0]         chan_en_q;
  logic [3:0]         filt_q;
  logic [7:0]         limit1_q, limit2_q;
  logic signed [15:0] temp_q [3];
  logic [2:0]         primed_q, crit1_q, crit2_q;
  logic               busy_q;
  logic [7:0]         ptr_q;
  logic [7:0]         sh_q;
  logic               wr_en, rd_load;

  wire [1:0] filt_r1 = filt_q[smbus_temp_pkg::FILT_R1_LSB +: 2];
  wire [1:0] filt_r2 = filt_q[smbus_temp_pkg::FILT_R2_LSB +: 2];
  wire fine_r1 = (filt_r1 == smbus_temp_pkg::FILT_BASIC) || (filt_r1 == smbus_temp_pkg::FILT_ENH);
  wire fine_r2 = (filt_r2 == smbus_temp_pkg::FILT_BASIC) || (filt_r2 == smbus_temp_pkg::FILT_ENH);

  // readable words per pair
  logic [15:0] word [NP];
  assign word[0] = fmt(temp_q[0], 1'b0, 1'b0);
  assign word[1] = fmt(temp_q[1], 1'b0, fine_r1);
  assign word[2] = fmt(temp_q[2], 1'b0, fine_r2);
  assign word[3] = fmt(temp_q[1], 1'b1, fine_r1);
  assign word[4] = fmt(temp_q[2], 1'b1, fine_r2);

  logic [NP-1:0] hit_hi, hit_lo, lock_q;
  logic [7:0]    lo_hold_q [NP];
  logic [7:0]    lo_byte [NP];
  for (genvar i = 0; i < NP; i++) begin : g_pair
    assign hit_hi[i]  = ptr_q == smbus_temp_pkg::OFS_MSB[i];
    assign hit_lo[i]  = ptr_q == smbus_temp_pkg::OFS_LSB[i];
    assign lo_byte[i] = lock_q[i] ? lo_hold_q[i] : word[i][7:0];
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        lock_q[i]    <= 1'b0;
        lo_hold_q[i] <= 8'h00;
      end else if (ce && rd_load) begin
        if (hit_hi[i]) begin
          lock_q[i]    <= 1'b1;
          lo_hold_q[i] <= word[i][7:0];
        end else if (hit_lo[i]) lock_q[i] <= 1'b0;
      end
    end
  end

  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == smbus_temp_pkg::OFS_STATUS) rd_byte = {busy_q, 7'h0};
    else if (ptr_q == smbus_temp_pkg::OFS_CHAN_EN) rd_byte = {5'h0, chan_en_q};
    else if (ptr_q == smbus_temp_pkg::OFS_FILTER) rd_byte = {4'h0, filt_q};
    else if (ptr_q == smbus_temp_pkg::OFS_LIMIT1) rd_byte = limit1_q;
    else if (ptr_q == smbus_temp_pkg::OFS_LIMIT2) rd_byte = limit2_q;
    for (int i = 0; i < NP; i++) begin
      if (hit_hi[i]) rd_byte = word[i][15:8];
      if (hit_lo[i]) rd_byte = lo_byte[i];
    end
  end

  // bus slave state machine
  bus_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_d, ptr_d;
  logic       rw_q, rw_d, oe_q, oe_d;
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    wr_en   = 1'b0;
    rd_load = 1'b0;
    if (to_hit || stop_ev) begin
      st_d = S_IDLE;
      oe_d = 1'b0;
    end else if (start_ev) begin
      st_d  = S_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else begin
      case (st_q)
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            oe_d  = 1'b1;
            if (st_q == S_ADDR) begin
              if (addr_done_q && sh_q[7:1] == slave_addr_q) begin
                rw_d = sh_q[0];
                st_d = S_ADDR_ACK;
              end else begin
                oe_d = 1'b0;
                st_d = S_IDLE;
              end
            end else if (st_q == S_CMD) begin
              ptr_d = sh_q;
              st_d  = S_CMD_ACK;
            end else begin
              wr_en = 1'b1;
              st_d  = S_WDATA_ACK;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              rd_load = 1'b1;
              sh_d    = rd_byte;
              oe_d    = ~rd_byte[7];
              cnt_d   = 4'h0;
              st_d    = S_READ;
            end else begin
              oe_d = 1'b0;
              st_d = S_CMD;
            end
          end
        end
        S_CMD_ACK, S_WDATA_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = S_WDATA;
          end
        end
        S_READ: begin
          if (scl_rise) cnt_d = cnt_q + 4'h1;
          else if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = S_READ_ACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        S_READ_ACK: begin
          if (scl_rise && sda) st_d = S_IDLE;
          else if (scl_fall) begin
            rd_load = 1'b1;
            sh_d    = rd_byte;
            oe_d    = ~rd_byte[7];
            cnt_d   = 4'h0;
            st_d    = S_READ;
          end
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q  <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
      ptr_q <= smbus_temp_pkg::OFS_POINTER_RESET;
      rw_q  <= 1'b0;
      oe_q  <= 1'b0;
    end else if (ce) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      ptr_q <= ptr_d;
      rw_q  <= rw_d;
      oe_q  <= oe_d;
    end
  end

  // register writes; temperature pairs and status ignore writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_en_q <= smbus_temp_pkg::CHAN_EN_RESET;
      filt_q    <= smbus_temp_pkg::FILTER_RESET;
      limit1_q  <= smbus_temp_pkg::LIMIT1_RESET;
      limit2_q  <= smbus_temp_pkg::LIMIT2_RESET;
    end else if (ce && wr_en) begin
      if (ptr_q == smbus_temp_pkg::OFS_CHAN_EN) chan_en_q <= sh_q[2:0];
      else if (ptr_q == smbus_temp_pkg::OFS_FILTER) filt_q <= sh_q[3:0];
      else if (ptr_q == smbus_temp_pkg::OFS_LIMIT1) limit1_q <= sh_q;
      else if (ptr_q == smbus_temp_pkg::OFS_LIMIT2) limit2_q <= sh_q;
    end
  end

  // conversion round sequencer
  seq_state_t    sq_q;
  logic [1:0]    chan_q;
  logic [GW-1:0] gap_q;
  wire [2:0] first_ch = first_from(chan_en_q, 3'h0);
  wire [2:0] next_ch  = first_from(chan_en_q, 3'(chan_q) + 3'h1);
  wire res_take = (sq_q == SQ_WAIT) && conv_result.done && (conv_result.chan == chan_q);

  // filter of the returning sample
  wire [1:0] mode = (chan_q == smbus_temp_pkg::CH_REMOTE1) ? filt_r1 :
                    (chan_q == smbus_temp_pkg::CH_REMOTE2) ? filt_r2 : smbus_temp_pkg::FILT_NONE;
  wire signed [16:0] x_in  = 17'($signed(conv_result.value));
  wire signed [16:0] y_old = 17'(temp_q[chan_q]);
  wire signed [16:0] x_clip = (mode != smbus_temp_pkg::FILT_ENH) ? x_in :
                              (x_in > y_old + smbus_temp_pkg::CLIP_STEP) ?
                              y_old + smbus_temp_pkg::CLIP_STEP :
                              (x_in < y_old - smbus_temp_pkg::CLIP_STEP) ?
                              y_old - smbus_temp_pkg::CLIP_STEP : x_in;
  wire filt_on = primed_q[chan_q] &&
                 (mode == smbus_temp_pkg::FILT_BASIC || mode == smbus_temp_pkg::FILT_ENH);
  wire signed [16:0] y_sum = y_old + ((x_clip - y_old) >>> smbus_temp_pkg::FILT_SHIFT);
  wire signed [15:0] y_new = filt_on ? y_sum[15:0] : conv_result.value;
  wire signed [16:0] y_ext = 17'(y_new);
  wire over1 = y_ext > $signed({1'b0, limit1_q, 5'h1f});
  wire over2 = y_ext > $signed({1'b0, limit2_q, 5'h1f});

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sq_q            <= SQ_GAP;
      chan_q          <= smbus_temp_pkg::CH_LOCAL;
      gap_q           <= '0;
      busy_q          <= 1'b0;
      conv_req.start  <= 1'b0;
      conv_req.chan   <= smbus_temp_pkg::CH_LOCAL;
    end else if (ce) begin
      conv_req.start <= 1'b0;
      case (sq_q)
        SQ_GAP: begin
          if (gap_q != '0) gap_q <= gap_q - GW'(1);
          else if (first_ch[2]) begin
            chan_q <= first_ch[1:0];
            busy_q <= 1'b1;
            sq_q   <= SQ_START;
          end
        end
        SQ_START: begin
          conv_req.start <= 1'b1;
          conv_req.chan  <= chan_q;
          sq_q           <= SQ_WAIT;
        end
        SQ_WAIT: begin
          if (res_take) begin
            if (next_ch[2]) begin
              chan_q <= next_ch[1:0];
              sq_q   <= SQ_START;
            end else begin
              busy_q <= 1'b0;
              gap_q  <= GW'(GAP_CYCLES_P - 1);
              sq_q   <= SQ_GAP;
            end
          end
        end
        default: sq_q <= SQ_GAP;
      endcase
    end
  end

  // result store and critical flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) temp_q[i] <= 16'sh0000;
      primed_q <= 3'h0;
      crit1_q  <= 3'h0;
      crit2_q  <= 3'h0;
    end else if (ce) begin
      crit1_q <= crit1_q & chan_en_q;
      crit2_q <= crit2_q & chan_en_q;
      if (res_take) begin
        temp_q[chan_q]   <= y_new;
        primed_q[chan_q] <= 1'b1;
        crit1_q[chan_q]  <= over1 & chan_en_q[chan_q];
        crit2_q[chan_q]  <= over2 & chan_en_q[chan_q];
      end
    end
  end

  // open-drain pins: level always low, enable pulls
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smb_dat_out                 <= 1'b0;
      smb_dat_oe                  <= 1'b0;
      critical_alarm_out_one      <= 1'b0;
      critical_alarm_out_one_oe   <= 1'b0;
      critical_alarm_out_two      <= 1'b0;
      critical_alarm_out_two_oe   <= 1'b0;
      critical_alarm_out_three    <= 1'b0;
      critical_alarm_out_three_oe <= 1'b0;
    end else if (ce) begin
      smb_dat_oe                  <= oe_d;
      critical_alarm_out_one_oe   <= crit1_q[1] | crit1_q[2];
      critical_alarm_out_two_oe   <= |crit2_q;
      critical_alarm_out_three_oe <= crit2_q[0];
    end
  end

endmodule

`default_nettype wire

// ### verification/smbus_temp_monitor.sv
// port checker for the temperature readout block
// assumes it is bound onto the readout top module
`timescale 1ns/1ps
`default_nettype none

module smbus_temp_monitor #(
  parameter int TIMEOUT_CYCLES_P = 200,
  parameter int GAP_CYCLES_P     = 50
) (
  // clock and reset
  input wire logic                         clk,
  input wire logic                         nrst,
  // bus pins
  input wire logic                         smb_clk_pin,
  input wire logic                         smb_dat_out,
  input wire logic                         smb_dat_oe,
  // converter
  input wire smbus_temp_pkg::conv_req_t    conv_req,
  input wire smbus_temp_pkg::conv_result_t conv_result,
  // alarms
  input wire logic                         critical_alarm_out_one,
  input wire logic                         critical_alarm_out_two,
  input wire logic                         critical_alarm_out_three
);
  logic pend_q;
  int   lo_q;
  int   idle_q;
  wire logic taken = conv_result.done && conv_result.chan == conv_req.chan && pend_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
      lo_q   <= 0;
      idle_q <= GAP_CYCLES_P;
    end else begin
      pend_q <= conv_req.start || (pend_q && !taken);
      lo_q   <= smb_clk_pin ? 0 : lo_q + 1;
      idle_q <= taken ? 0 : (idle_q < GAP_CYCLES_P ? idle_q + 1 : idle_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // result taken, then the next request
  sequence next_s;
    taken ##2 conv_req.start;
  endsequence

  dat_low_a: assert property (smb_dat_out == 1'b0)
    else $error("data pin driven high");
  alarm_low_a: assert property ({critical_alarm_out_one, critical_alarm_out_two,
    critical_alarm_out_three} == 3'h0)
    else $error("alarm pin driven high");
  dat_edge_a: assert property ($changed(smb_dat_oe) && lo_q < 100
    |-> lo_q inside {[2:6]})
    else $error("data changed outside clock low phase");
  bus_timeout_a: assert property (lo_q > TIMEOUT_CYCLES_P + 8 |-> !smb_dat_oe)
    else $error("data held past bus timeout");
  start_pulse_a: assert property (conv_req.start |=> !conv_req.start)
    else $error("start longer than one cycle");
  chan_legal_a: assert property (conv_req.start |-> conv_req.chan != 2'h3)
    else $error("request for a fourth channel");
  chan_order_a: assert property (next_s |-> conv_req.chan > $past(conv_req.chan))
    else $error("channels not ascending in a round");
  one_pending_a: assert property (conv_req.start |-> !pend_q)
    else $error("second request while one pending");
  round_gap_a: assert property (conv_req.start && !$past(taken, 2)
    |-> idle_q >= GAP_CYCLES_P - 2)
    else $error("round started before idle gap");
endmodule

bind smbus_temp_sensor_readout smbus_temp_monitor #(
  .TIMEOUT_CYCLES_P(TIMEOUT_CYCLES_P),
  .GAP_CYCLES_P(GAP_CYCLES_P)
) mon (.clk, .nrst, .smb_clk_pin, .smb_dat_out, .smb_dat_oe, .conv_req, .conv_result,
  .critical_alarm_out_one, .critical_alarm_out_two, .critical_alarm_out_three);

`default_nettype wire

// ### verification/smbus_temp_sensor_readout_tb_top.sv
// bench for the temperature readout block: bus master tasks and tests
// assumes the converter model and the bound port checker
`timescale 1ns/1ps
`default_nettype none

module smbus_temp_sensor_readout_tb_top;
  localparam int TO = 2000;
  localparam logic [6:0]  ADDR [3] = '{7'h18, 7'h2a, 7'h2b};
  localparam logic [1:0]  SELV [3] = '{2'h0, 2'h1, 2'h2};
  localparam logic [7:0]  FCODE [3] = '{8'h05, 8'h0a, 8'h00};
  localparam logic [15:0] EXPW [5] = '{16'h1920, 16'h0008, 16'h7ff8, 16'h0008, 16'hd000};
  logic             clk, nrst, scl, sda_m, clr, hold, dat_out, dat_oe;
  logic [1:0]       sel;
  logic [2:0]       al, al_oe;
  logic [2:0][15:0] temps;
  logic [2:0][7:0]  starts;
  logic [6:0]       dev;
  int               fail_count, num_checks;
  smbus_temp_pkg::conv_req_t    req;
  smbus_temp_pkg::conv_result_t res;
  // pulled-up wire
  wire logic        sda = sda_m & ~dat_oe;

  smbus_temp_sensor_readout #(.TIMEOUT_CYCLES_P(TO), .GAP_CYCLES_P(50)) uut (
    .clk, .nrst, .ce(1'b1), .smb_clk_pin(scl), .smb_dat_in(sda), .smb_dat_out(dat_out),
    .smb_dat_oe(dat_oe), .address_select_pin(sel), .conv_req(req), .conv_result(res),
    .critical_alarm_out_one(al[0]), .critical_alarm_out_one_oe(al_oe[0]),
    .critical_alarm_out_two(al[1]), .critical_alarm_out_two_oe(al_oe[1]),
    .critical_alarm_out_three(al[2]), .critical_alarm_out_three_oe(al_oe[2]));
  temp_conv_model #(.DLY(20)) conv (.clk, .nrst, .conv_req(req), .conv_result(res),
    .temps, .clr, .hold, .starts);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one clock pulse: data set in low phase, sampled in high phase
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    cyc(3);
    sda_m <= b;
    cyc(4);
    scl <= 1'b1;
    cyc(3);
    #1 r = sda;
    cyc(3);
  endtask
  task automatic start;
    logic r;
    bit_io(1'b1, r);
    sda_m <= 1'b0;
    cyc(3);
  endtask
  task automatic stop;
    logic r;
    bit_io(1'b0, r);
    sda_m <= 1'b1;
    cyc(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
                      output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, r);
    a = !r;
  endtask
  task automatic probe(input logic exp);
    logic [7:0] q;
    logic       k;
    start;
    xfer({dev, 1'b0}, 1'b1, q, k);
    stop;
    check(k, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    logic       k;
    start;
    xfer({dev, 1'b0}, 1'b1, q, k);
    check(k, 1'b1);
    xfer(a, 1'b1, q, k);
    xfer(v, 1'b1, q, k);
    stop;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    logic k;
    start;
    xfer({dev, 1'b0}, 1'b1, q, k);
    xfer(a, 1'b1, q, k);
    start;
    xfer({dev, 1'b1}, 1'b1, q, k);
    check(k, 1'b1);
    xfer(8'hff, 1'b1, q, k);
    stop;
  endtask

  initial begin
    logic [7:0] b;
    logic       r;
    nrst = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    clr = 1'b0;
    hold = 1'b0;
    sel = 2'h0;
    dev = 7'h18;
    temps = {16'h1a00, 16'h0001, 16'h0325};
    fail_count = 0;
    num_checks = 0;
    for (int i = 0; i < 3; i++) begin
      sel <= SELV[i];
      nrst <= 1'b0;
      cyc(5);
      nrst <= 1'b1;
      cyc(20);
      dev = ADDR[i];
      probe(1'b1);
      dev = ADDR[(i + 1) % 3];
      probe(1'b0);
    end
    dev = 7'h2b;
    sel <= 2'h0;
    cyc(10);
    probe(1'b1);
    rd(smbus_temp_pkg::OFS_FILTER, b);
    check(b, 8'h0f);
    rd(smbus_temp_pkg::OFS_CHAN_EN, b);
    check(b, 8'h07);
    for (int i = 0; i < 5; i++) begin
      rd(smbus_temp_pkg::OFS_MSB[i], b);
      check(b, EXPW[i][15:8]);
      rd(smbus_temp_pkg::OFS_LSB[i], b);
      check(b, EXPW[i][7:0]);
    end
    check(al_oe, 3'h3);
    for (int i = 0; i < 3; i++) begin
      wr(smbus_temp_pkg::OFS_FILTER, FCODE[i]);
      rd(smbus_temp_pkg::OFS_FILTER, b);
      check(b, FCODE[i]);
      rd(smbus_temp_pkg::OFS_LSB[1], b);
      check(b, (i == 0) ? 8'h08 : 8'h00);
    end
    temps[1] <= 16'h0004;
    cyc(300);
    rd(smbus_temp_pkg::OFS_LSB[1], b);
    check(b, 8'h20);
    wr(smbus_temp_pkg::OFS_MSB[0], 8'h55);
    rd(smbus_temp_pkg::OFS_MSB[0], b);
    check(b, 8'h19);
    temps[0] <= 16'h0348;
    cyc(300);
    rd(smbus_temp_pkg::OFS_LSB[0], b);
    check(b, 8'h20);
    rd(smbus_temp_pkg::OFS_LSB[0], b);
    check(b, 8'h40);
    temps[0] <= 16'h1000;
    cyc(300);
    rd(smbus_temp_pkg::OFS_MSB[0], b);
    check(b, 8'h7f);
    rd(smbus_temp_pkg::OFS_LSB[0], b);
    check(b, 8'he0);
    check(al_oe, 3'h7);
    wr(smbus_temp_pkg::OFS_CHAN_EN, 8'h02);
    cyc(300);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(600);
    check(starts[0], 8'h00);
    check(starts[2], 8'h00);
    check(starts[1] >= 8'h07, 1'b1);
    check(al_oe, 3'h0);
    // converter stalled mid-round keeps busy up; no channels leaves it down
    hold <= 1'b1;
    cyc(200);
    rd(smbus_temp_pkg::OFS_STATUS, b);
    check(b, 8'h80);
    wr(smbus_temp_pkg::OFS_CHAN_EN, 8'h00);
    hold <= 1'b0;
    cyc(100);
    rd(smbus_temp_pkg::OFS_STATUS, b);
    check(b, 8'h00);
    // stall the clock low inside the acknowledge bit
    start;
    for (int i = 7; i >= 1; i--) bit_io(dev[i - 1], r);
    bit_io(1'b0, r);
    scl <= 1'b0;
    cyc(8);
    check(dat_oe, 1'b1);
    cyc(TO + 20);
    check(dat_oe, 1'b0);
    scl <= 1'b1;
    cyc(10);
    probe(1'b1);
    final_report;
  end

  initial begin
    cyc(40000);
    fail_count++;
    final_report;
  end
endmodule

`default_nettype wire

// ### verification/temp_conv_model.sv
// converter model answering each start after a fixed delay
// assumes the bench sets the per-channel readings
`timescale 1ns/1ps
`default_nettype none

module temp_conv_model #(
  parameter int DLY = 20
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // request and answer
  input  wire smbus_temp_pkg::conv_req_t    conv_req,
  output smbus_temp_pkg::conv_result_t      conv_result,
  // bench side
  input  wire logic [2:0][15:0]             temps,
  input  wire logic                         clr,
  // stalls the pending answer while high
  input  wire logic                         hold,
  output logic [2:0][7:0]                   starts
);
  int         wait_q;
  logic [1:0] chan_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q      <= 0;
      chan_q      <= 2'h0;
      starts      <= '0;
      conv_result <= '0;
    end else begin
      conv_result.done  <= 1'b0;
      // value is junk outside the done strobe
      conv_result.value <= ~conv_result.value;
      if (clr)
        starts <= '0;
      if (wait_q != 0 && !hold)
        wait_q <= wait_q - 1;
      if (wait_q == 1 && !hold)
        conv_result <= '{1'b1, chan_q, temps[chan_q]};
      if (conv_req.start) begin
        wait_q <= DLY;
        chan_q <= conv_req.chan;
        starts[conv_req.chan] <= starts[conv_req.chan] + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire
